/* rtl/kbd_rx_top.sv */
/*
  Receive path of a keyboard or mouse two-wire serial channel with an
  AHB-Lite register slave and a level interrupt.
  Assumes the peripheral drives the clock line and both lines have pull-ups.

  // Operation
  // - Enabled in receive direction, both lines float within 1000 ns.
  // - Each data bit is captured on a falling edge of the peripheral clock.
  // - The byte-ready flag sets within 1.6 us of the eleventh falling edge.
  // - Reading receive data clears byte-ready within 500 ns.
  // - Finishing that read releases the clock line to high impedance.
  // - With the channel disabled, clock is driven low and data floats.
  // - A set byte-ready flag raises an interrupt request.
*/
// Decided for this implementation: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
module kbd_rx_top (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic periph_clock_line_i,
  output logic periph_clock_line_o,
  output logic periph_clock_line_oe,
  input wire logic periph_data_line_i,
  output logic periph_data_line_o,
  output logic periph_data_line_oe,
  output logic irq
);
  import kbd_rx_pkg::*;

  logic [1:0] ctrl_reg;
  logic [ST_W-1:0] stat_reg;
  logic [ST_W-1:0] mask_reg;
  logic [7:0] rxdata_reg;
  logic hold_reg;
  logic [1:0] ck_sync_reg;
  logic [1:0] dt_sync_reg;
  logic ck_prev_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic rd_done_reg;
  logic done;
  rx_byte_t result;
  line_drive_t drv;
  logic fall;
  logic bus_go;
  logic channel_enable;
  logic transfer_direction;
  logic [ST_W-1:0] w1c;
  logic [ST_W-1:0] stat_next;

  function automatic logic [31:0] zext8(input logic [7:0] v);
    zext8 = {24'h000000, v};
  endfunction : zext8

  function automatic logic [31:0] zexts(input logic [ST_W-1:0] v);
    zexts = {{(32 - ST_W){1'b0}}, v};
  endfunction : zexts

  assign channel_enable = ctrl_reg[CTRL_EN_BIT];
  assign transfer_direction = ctrl_reg[CTRL_DIR_BIT];
  assign bus_go = hsel && hready && (htrans == HTRANS_NONSEQ);

  // Pin inputs pass two flip-flops; only the second stage is read.
  // Reset values match the idle high line, so release brings no false edge.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ck_sync_reg <= 2'h3;
      dt_sync_reg <= 2'h3;
      ck_prev_reg <= 1'b1;
    end else if (ce) begin
      ck_sync_reg <= {ck_sync_reg[0], periph_clock_line_i};
      dt_sync_reg <= {dt_sync_reg[0], periph_data_line_i};
      ck_prev_reg <= ck_sync_reg[1];
    end
  end

  // Edges count only while enabled, receiving and not holding the line.
  assign fall = ck_prev_reg & ~ck_sync_reg[1] & channel_enable
    & ~transfer_direction & ~hold_reg;

  kbd_rx_frame frame_u (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ce(ce),
    .clear(~channel_enable | transfer_direction),
    .fall(fall),
    .data_bit(dt_sync_reg[1]),
    .done(done),
    .result(result)
  );

  // AHB write: address phase is latched, data arrives the next cycle.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else if (ce) begin
      if (hready) begin
        wr_pend_reg <= bus_go & hwrite;
        wr_addr_reg <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= CTRL_RST;
      mask_reg <= MASK_RST;
    end else if (ce) begin
      if (wr_pend_reg) begin
        if (wr_addr_reg == CTRL_OFS) begin
          ctrl_reg <= hwdata[1:0];
        end else if (wr_addr_reg == MASK_OFS) begin
          mask_reg <= hwdata[ST_W-1:0];
        end
      end
    end
  end

  // Read data is registered in the address phase, valid in the data phase.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h00000000;
      rd_done_reg <= 1'b0;
    end else if (ce) begin
      rd_done_reg <= 1'b0;
      if (bus_go && !hwrite) begin
        if (haddr[7:0] == CTRL_OFS) begin
          hrdata <= {30'h0, ctrl_reg};
        end else if (haddr[7:0] == RXDATA_OFS) begin
          hrdata <= zext8(rxdata_reg);
          rd_done_reg <= 1'b1;
        end else if (haddr[7:0] == STAT_OFS) begin
          hrdata <= zexts(stat_reg);
        end else if (haddr[7:0] == MASK_OFS) begin
          hrdata <= zexts(mask_reg);
        end else begin
          hrdata <= 32'h00000000;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Reading the byte clears its ready flag as a one written to it would.
  always_comb begin
    w1c = '0;
    if (wr_pend_reg && wr_addr_reg == STAT_OFS) begin
      w1c = hwdata[ST_W-1:0];
    end
    w1c[ST_RDY_BIT] = w1c[ST_RDY_BIT] | rd_done_reg;
    stat_next = stat_reg & ~w1c;
    // A new frame wins over a clear in the same cycle.
    if (done) begin
      stat_next[ST_RDY_BIT] = 1'b1;
      stat_next[ST_PERR_BIT] = stat_reg[ST_PERR_BIT] | result.par_err;
      stat_next[ST_FERR_BIT] = stat_reg[ST_FERR_BIT] | result.frm_err;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stat_reg <= '0;
      rxdata_reg <= 8'h00;
    end else if (ce) begin
      stat_reg <= stat_next;
      if (done) begin
        rxdata_reg <= result.data;
      end
    end
  end

  // The clock is held low from the stop bit until the byte is read.
  // Holding the line is the only flow control; an unread byte stalls it.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hold_reg <= 1'b0;
    end else if (ce) begin
      if (!channel_enable || transfer_direction) begin
        hold_reg <= 1'b0;
      end else if (done) begin
        hold_reg <= 1'b1;
      end else if (rd_done_reg) begin
        hold_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    drv.clk_o = 1'b0;
    drv.dat_o = 1'b0;
    drv.dat_oe = 1'b0;
    if (!channel_enable) begin
      drv.clk_oe = 1'b1;
    end else if (!transfer_direction) begin
      drv.clk_oe = hold_reg | done;
    end else begin
      // Transmit is handled elsewhere; the clock is inhibited here.
      drv.clk_oe = 1'b1;
    end
  end

  // The interrupt follows the next status, so it rises with the flag.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      periph_clock_line_o <= 1'b0;
      periph_clock_line_oe <= 1'b1;
      periph_data_line_o <= 1'b0;
      periph_data_line_oe <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      periph_clock_line_o <= drv.clk_o;
      periph_clock_line_oe <= drv.clk_oe;
      periph_data_line_o <= drv.dat_o;
      periph_data_line_oe <= drv.dat_oe;
      irq <= |(stat_next & mask_reg);
    end
  end

  float_rx_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && channel_enable && !transfer_direction && !hold_reg && !done
    |=> !periph_clock_line_oe && !periph_data_line_oe)
    else $error("lines not floated in receive");

  rdy_set_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && done |=> stat_reg[ST_RDY_BIT])
    else $error("byte ready not set after frame");

  rd_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && rd_done_reg && !done |=> !stat_reg[ST_RDY_BIT])
    else $error("byte ready not cleared by read");

  rd_release_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && rd_done_reg && !done && channel_enable && !transfer_direction
    |=> ##1 !periph_clock_line_oe)
    else $error("clock not released after read");

  off_drive_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && !channel_enable |=> periph_clock_line_oe && !periph_clock_line_o
    && !periph_data_line_oe)
    else $error("disabled line state wrong");

  irq_raise_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && done && mask_reg[ST_RDY_BIT] && !(wr_pend_reg && wr_addr_reg ==
    MASK_OFS) |=> irq)
    else $error("interrupt not raised");

  hold_low_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && done && channel_enable && !transfer_direction
    |=> periph_clock_line_oe ##1 periph_clock_line_oe)
    else $error("clock not held after stop bit");

  edge_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    fall |-> $past(ck_sync_reg[1]) && !ck_sync_reg[1])
    else $error("bit taken off a falling edge");

  irq_lvl_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    stat_reg[ST_RDY_BIT] && mask_reg[ST_RDY_BIT] && $stable(mask_reg)
    |-> irq)
    else $error("interrupt low with byte ready unmasked");

  rdy_keep_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && stat_reg[ST_RDY_BIT] && !rd_done_reg
    && !(wr_pend_reg && wr_addr_reg == STAT_OFS && hwdata[ST_RDY_BIT])
    |=> stat_reg[ST_RDY_BIT])
    else $error("byte ready dropped without a read");

  hold_drv_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    hold_reg |-> periph_clock_line_oe)
    else $error("clock released while holding a byte");

  done_one_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && done |=> !done)
    else $error("frame done longer than one cycle");

  off_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ce && !channel_enable |=> !hold_reg)
    else $error("byte hold kept while disabled");

endmodule : kbd_rx_top

/* rtl/kbd_rx_pkg.sv */
/*
  Package for the keyboard and mouse serial receiver: register map, field
  positions, reset values, timing counts and shared types.
  Assumes a 100 MHz system clock and a 32-bit AHB-Lite register bus.
*/
package kbd_rx_pkg;

  localparam int CLK_PERIOD_NS = 10;

  // Line release after enable in receive direction, longest time.
  localparam int FLOAT_MAX_NS = 1000;
  localparam int FLOAT_CYC = FLOAT_MAX_NS / CLK_PERIOD_NS;
  // Byte-ready after the eleventh falling edge, longest time.
  localparam int RDY_MAX_NS = 1600;
  localparam int RDY_CYC = RDY_MAX_NS / CLK_PERIOD_NS;
  // Ready cleared after the read strobe ends, longest time.
  localparam int CLR_MAX_NS = 500;
  localparam int CLR_CYC = CLR_MAX_NS / CLK_PERIOD_NS;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] RXDATA_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] MASK_OFS = 8'h0c;

  // Control fields.
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_DIR_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // Status and mask fields.
  localparam int ST_RDY_BIT = 0;
  localparam int ST_PERR_BIT = 1;
  localparam int ST_FERR_BIT = 2;
  localparam int ST_W = 3;
  localparam logic [ST_W-1:0] MASK_RST = 3'h0;

  localparam int FRAME_BITS = 11;
  localparam logic [3:0] LAST_BIT_IDX = 4'ha;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic clk_o;
    logic clk_oe;
    logic dat_o;
    logic dat_oe;
  } line_drive_t;

  typedef struct packed {
    logic [7:0] data;
    logic par_err;
    logic frm_err;
  } rx_byte_t;

endpackage : kbd_rx_pkg

/* rtl/kbd_rx_frame.sv */
/*
  Frame shifter: takes one bit per falling edge of the peripheral clock and
  reports a finished eleven-bit frame with its byte and error flags.
  Assumes the caller gives synchronised line samples and a falling-edge pulse.
*/
`timescale 1ns/10ps
module kbd_rx_frame (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic clear,
  input wire logic fall,
  input wire logic data_bit,
  output logic done,
  output kbd_rx_pkg::rx_byte_t result
);
  import kbd_rx_pkg::*;

  logic [3:0] cnt_reg;
  logic [9:0] shift_reg;

  // Each bit is taken on a falling clock edge, LSB first.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 4'h0;
      shift_reg <= 10'h000;
      done <= 1'b0;
      result <= '0;
    end else if (ce) begin
      done <= 1'b0;
      if (clear) begin
        cnt_reg <= 4'h0;
      end else if (fall) begin
        if (cnt_reg == LAST_BIT_IDX) begin
          cnt_reg <= 4'h0;
          done <= 1'b1;
          result.data <= shift_reg[8:1];
          result.par_err <= ~(^shift_reg[9:1]);
          result.frm_err <= shift_reg[0] | ~data_bit;
        end else begin
          cnt_reg <= cnt_reg + 4'h1;
          shift_reg <= {data_bit, shift_reg[9:1]};
        end
      end
    end
  end

  cnt_range_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cnt_reg <= LAST_BIT_IDX)
    else $error("bit counter past the stop bit");

endmodule : kbd_rx_frame

/* sim/kbd_periph.sv */
/*
  Behavioural keyboard or mouse that drives the link clock and sends frames.
  Assumes pull-ups on both lines, so a released output reads high.
*/
`timescale 1ns/10ps
module kbd_periph (
  input wire logic clk_line,
  output logic clk_low,
  output logic dat_low
);
  realtime t_fall;

  // The link clock stands high between frames; half period is 40 ns.
  task automatic send(input logic [7:0] b, input logic bad_par,
                      input logic bad_stop);
    logic [10:0] f;
    f = {~bad_stop, ~^b ^ bad_par, b, 1'b0};
    wait (clk_line === 1'b1);
    #3;
    for (int i = 0; i < 11; i++) begin
      dat_low = ~f[i];
      #20;
      clk_low = 1'b1;
      t_fall = $realtime;
      #40;
      clk_low = 1'b0;
      #20;
    end
    dat_low = 1'b0;
  endtask : send

  initial begin
    clk_low = 1'b0;
    dat_low = 1'b0;
  end
endmodule : kbd_periph

/* sim/kbd_mouse_serial_receiver_tb_top.sv */
/*
  Self-checking bench for the serial receiver: register bus tasks, frames
  from the peripheral model, line states and the interrupt.
  Assumes pull-ups on both lines and a single bus slave.
*/
`timescale 1ns/10ps
module kbd_mouse_serial_receiver_tb_top;
  import kbd_rx_pkg::*;
  logic sys_clk, nrst, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic clk_low, dat_low, co, coe, dout, doe, ce;
  logic [7:0] bytes [3] = '{8'h01, 8'h80, 8'h5a};
  int n_fail, total_checks;
  wire clk_w = ~clk_low & (~coe | co);
  wire dat_w = ~dat_low & (~doe | dout);

  kbd_rx_top i_dut (.sys_clk(sys_clk), .nrst(nrst), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .periph_clock_line_i(clk_w),
    .periph_clock_line_o(co), .periph_clock_line_oe(coe),
    .periph_data_line_i(dat_w), .periph_data_line_o(dout),
    .periph_data_line_oe(doe), .irq(irq));

  kbd_periph i_per (.clk_line(clk_w), .clk_low(clk_low), .dat_low(dat_low));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic wrap_up;
    $display("checks=%0d failures=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One single transfer; waits on the slave's ready in both phases.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  initial begin
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    ce = 1'b1;
    hwdata = 32'h0;
    repeat (20) @(posedge sys_clk);
    chk({30'h0, coe, doe}, 32'h2);
    nrst <= 1'b1;
    rd(CTRL_OFS, 32'h0);
    rd(MASK_OFS, 32'h0);
    rd(8'h10, 32'h0);
    wr(CTRL_OFS, 32'h1);
    repeat (FLOAT_CYC) @(posedge sys_clk);
    chk({30'h0, coe, doe}, 32'h0);
    wr(MASK_OFS, 32'h1);
    // The parity error stays sticky, so later frames keep status bit 1.
    for (int k = 0; k < 3; k++) begin
      i_per.send(bytes[k], k == 1, 1'b0);
      #(i_per.t_fall + RDY_MAX_NS - 2 - $realtime);
      chk({30'h0, irq, coe}, 32'h3);
      rd(STAT_OFS, (k != 0) ? 32'h3 : 32'h1);
      rd(RXDATA_OFS, {24'h0, bytes[k]});
      repeat (CLR_CYC) @(posedge sys_clk);
      chk({30'h0, irq, coe}, 32'h0);
      rd(STAT_OFS, (k != 0) ? 32'h2 : 32'h0);
    end
    wr(MASK_OFS, 32'h2);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    wr(STAT_OFS, 32'h2);
    rd(STAT_OFS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // A low stop bit sets the framing flag; the byte is still stored.
    i_per.send(8'h3c, 1'b0, 1'b1);
    #(i_per.t_fall + RDY_MAX_NS - 2 - $realtime);
    chk({30'h0, irq, coe}, 32'h1);
    rd(STAT_OFS, 32'h5);
    rd(RXDATA_OFS, 32'h3c);
    wr(STAT_OFS, 32'h4);
    rd(STAT_OFS, 32'h0);
    // With the clock enable low the write must leave no trace.
    ce <= 1'b0;
    wr(CTRL_OFS, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk({30'h0, coe, doe}, 32'h0);
    ce <= 1'b1;
    wr(CTRL_OFS, 32'h3);
    repeat (3) @(posedge sys_clk);
    chk({30'h0, coe, doe}, 32'h2);
    wr(CTRL_OFS, 32'h1);
    repeat (3) @(posedge sys_clk);
    chk({30'h0, coe, doe}, 32'h0);
    wr(CTRL_OFS, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk({30'h0, coe, doe}, 32'h2);
    wrap_up;
  end

  initial begin
    #200000;
    n_fail++;
    wrap_up;
  end
endmodule : kbd_mouse_serial_receiver_tb_top
